//--- shared/cmer_defs.vh
// Summary of operation
// - Garbage report when structure missing
// - Garbage report has no data fields
// - Unknown report for unsupported command/extension
// - Other reports echo 7+3 character words
// - Syntax report for badly formatted field
// - Semantic report for out-of-range value
// - Sequence report for out-of-order message
// - Report goes back to sender
// - Report word only for protocol errors
`ifndef CMER_DEFS_VH
`define CMER_DEFS_VH
`define CMER_CMD_LEN 7
`define CMER_EXT_LEN 3
`define CMER_CHAR_W 8
`define CMER_CLS_W 3
`define CMER_CLS_NONE 3'h0
`define CMER_CLS_GBG 3'h1
`define CMER_CLS_UKN 3'h2
`define CMER_CLS_SYN 3'h3
`define CMER_CLS_SEM 3'h4
`define CMER_CLS_PRT 3'h5
`define CMER_SRC_W 4
`define CMER_REPLY_LEN_BARE 4'h2
`define CMER_REPLY_LEN_ECHO 4'h4
`endif

//--- hw/cmer_classify.v
`timescale 1ns/1ps
`include "cmer_defs.vh"
// Priority picker over the five error classes
module cmer_classify (
  input wire no_structure,
  input wire unknown_cmd,
  input wire syntax_bad,
  input wire semantic_bad,
  input wire order_bad,
  output reg [`CMER_CLS_W-1:0] err_class
);
  // Earlier checks make later ones meaningless, so the first one wins
  always @* begin
    if (no_structure) begin
      err_class = `CMER_CLS_GBG;
    end else if (unknown_cmd) begin
      err_class = `CMER_CLS_UKN;
    end else if (syntax_bad) begin
      err_class = `CMER_CLS_SYN;
    end else if (semantic_bad) begin
      err_class = `CMER_CLS_SEM;
    end else if (order_bad) begin
      err_class = `CMER_CLS_PRT;
    end else begin
      err_class = `CMER_CLS_NONE;
    end
  end
endmodule // cmer_classify

//--- hw/cmer_reporter.v
`timescale 1ns/1ps
`include "cmer_defs.vh"
// Turns checker verdicts on one received message into at most one error reply
module cmer_reporter #(
  parameter SRC_W = `CMER_SRC_W
) (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire msg_valid,
  output wire msg_ready,
  input wire [SRC_W-1:0] msg_src,
  input wire [`CMER_CMD_LEN*`CMER_CHAR_W-1:0] msg_cmd,
  input wire [`CMER_EXT_LEN*`CMER_CHAR_W-1:0] msg_ext,
  input wire no_structure,
  input wire unknown_cmd,
  input wire syntax_bad,
  input wire semantic_bad,
  input wire order_bad,
  output wire rep_valid,
  input wire rep_ready,
  output reg [SRC_W-1:0] rep_dest_r,
  output reg [`CMER_CLS_W-1:0] rep_class_r,
  output reg rep_echo_r,
  output reg [3:0] rep_fields_r,
  output reg [`CMER_CMD_LEN*`CMER_CHAR_W-1:0] rep_cmd_r,
  output reg [`CMER_EXT_LEN*`CMER_CHAR_W-1:0] rep_ext_r,
  output reg msg_ok_r
);
  // Lane and word widths
  localparam CW = `CMER_CHAR_W;
  localparam CMD_W = `CMER_CMD_LEN * `CMER_CHAR_W;
  localparam EXT_W = `CMER_EXT_LEN * `CMER_CHAR_W;

  // Reply slot states: empty, or one reply waiting for the far end
  localparam ST_IDLE = 1'b0;
  localparam ST_HOLD = 1'b1;

  // Verdict of the priority picker
  wire [`CMER_CLS_W-1:0] err_class;

  // Handshake qualifiers
  wire take_msg;
  wire take_err;
  wire drain_rep;
  wire echo_now;

  // Echo lanes, blanked for replies that carry no words
  wire [CMD_W-1:0] cmd_lane;
  wire [EXT_W-1:0] ext_lane;

  // Slot state
  reg st_r;
  reg st_nxt;

  // Next values of the reply register
  reg [SRC_W-1:0] rep_dest_nxt;
  reg [`CMER_CLS_W-1:0] rep_class_nxt;
  reg rep_echo_nxt;
  reg [3:0] rep_fields_nxt;
  reg [CMD_W-1:0] rep_cmd_nxt;
  reg [EXT_W-1:0] rep_ext_nxt;
  reg msg_ok_nxt;

  // Any class other than none is a protocol error worth a reply
  function cls_is_error;
    input [`CMER_CLS_W-1:0] cls;
    begin
      cls_is_error = (cls != `CMER_CLS_NONE);
    end
  endfunction

  // Classes whose reply echoes the offending command and extension
  function cls_echoes;
    input [`CMER_CLS_W-1:0] cls;
    begin
      case (cls)
        `CMER_CLS_UKN: cls_echoes = 1'b1;
        `CMER_CLS_SYN: cls_echoes = 1'b1;
        `CMER_CLS_SEM: cls_echoes = 1'b1;
        `CMER_CLS_PRT: cls_echoes = 1'b1;
        default: cls_echoes = 1'b0;
      endcase
    end
  endfunction

  // Number of words in the reply, command and extension included
  function [3:0] cls_fields;
    input [`CMER_CLS_W-1:0] cls;
    begin
      case (cls)
        `CMER_CLS_GBG: cls_fields = `CMER_REPLY_LEN_BARE;
        `CMER_CLS_UKN: cls_fields = `CMER_REPLY_LEN_ECHO;
        `CMER_CLS_SYN: cls_fields = `CMER_REPLY_LEN_ECHO;
        `CMER_CLS_SEM: cls_fields = `CMER_REPLY_LEN_ECHO;
        `CMER_CLS_PRT: cls_fields = `CMER_REPLY_LEN_ECHO;
        default: cls_fields = 4'h0;
      endcase
    end
  endfunction

  cmer_classify u_cls (
    .no_structure(no_structure),
    .unknown_cmd(unknown_cmd),
    .syntax_bad(syntax_bad),
    .semantic_bad(semantic_bad),
    .order_bad(order_bad),
    .err_class(err_class)
  );

  // One reply held at a time; a new message waits until it is taken
  assign msg_ready = clk_en & (st_r == ST_IDLE);
  assign rep_valid = (st_r == ST_HOLD);

  // Handshake events; a low enable freezes both sides of the slot
  assign take_msg = clk_en & msg_valid & (st_r == ST_IDLE);
  assign take_err = take_msg & cls_is_error(err_class);
  assign drain_rep = clk_en & rep_ready & (st_r == ST_HOLD);
  assign echo_now = cls_echoes(err_class);

  // Command lanes; a garbage reply must not leak a stale word
  genvar gi;
  generate
    for (gi = 0; gi < `CMER_CMD_LEN; gi = gi + 1) begin : g_cmd_lane
      assign cmd_lane[gi*CW +: CW] = echo_now ? msg_cmd[gi*CW +: CW] : {CW{1'b0}};
    end
  endgenerate

  // Extension lanes, same treatment as the command lanes
  genvar gj;
  generate
    for (gj = 0; gj < `CMER_EXT_LEN; gj = gj + 1) begin : g_ext_lane
      assign ext_lane[gj*CW +: CW] = echo_now ? msg_ext[gj*CW +: CW] : {CW{1'b0}};
    end
  endgenerate

  // Slot control: fill on an erroneous message, empty on acceptance
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (take_err) begin
          st_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (drain_rep) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Reply contents; held unchanged while the far end stalls
  always @* begin
    rep_dest_nxt = rep_dest_r;
    rep_class_nxt = rep_class_r;
    rep_echo_nxt = rep_echo_r;
    rep_fields_nxt = rep_fields_r;
    rep_cmd_nxt = rep_cmd_r;
    rep_ext_nxt = rep_ext_r;
    if (take_err) begin
      rep_dest_nxt = msg_src;
      rep_class_nxt = err_class;
      rep_echo_nxt = echo_now;
      rep_fields_nxt = cls_fields(err_class);
      rep_cmd_nxt = cmd_lane;
      rep_ext_nxt = ext_lane;
    end
  end

  // Clean messages get no reply, only a status pulse
  always @* begin
    msg_ok_nxt = take_msg & ~cls_is_error(err_class);
  end

  // Slot state register
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Reply register; stable from fill to acceptance
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rep_dest_r <= {SRC_W{1'b0}};
      rep_class_r <= `CMER_CLS_NONE;
      rep_echo_r <= 1'b0;
      rep_fields_r <= 4'h0;
      rep_cmd_r <= {CMD_W{1'b0}};
      rep_ext_r <= {EXT_W{1'b0}};
    end else if (clk_en) begin
      rep_dest_r <= rep_dest_nxt;
      rep_class_r <= rep_class_nxt;
      rep_echo_r <= rep_echo_nxt;
      rep_fields_r <= rep_fields_nxt;
      rep_cmd_r <= rep_cmd_nxt;
      rep_ext_r <= rep_ext_nxt;
    end
  end

  // Status pulse; stretched only by a low enable, never repeated
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      msg_ok_r <= 1'b0;
    end else if (clk_en) begin
      msg_ok_r <= msg_ok_nxt;
    end
  end

  // Limitation: one reply slot only, so a stalled far end also stalls
  // the incoming message stream; a deeper queue was not worth the area
  // for a channel that carries a few messages per second at most.
endmodule // cmer_reporter

//--- tb/cmer_remote.sv
`timescale 1ns/1ps
// Reply consumer at the far end; when slow it stalls at random
module cmer_remote (input logic sys_clk, slow, output logic rep_ready = 1'b1);
  always @(posedge sys_clk) rep_ready <= #1 !slow || $urandom_range(1);
endmodule // cmer_remote

//--- tb/cmer_reporter_monitor.sv
`timescale 1ns/1ps
// Reply class, field and echo checks against the verdict flags
module cmer_reporter_monitor #(parameter SRC_W = 4) (
  input logic sys_clk, rst_n, clk_en, msg_valid, msg_ready, rep_valid, rep_echo_r, msg_ok_r,
  input logic no_structure, unknown_cmd, syntax_bad, semantic_bad, order_bad,
  input logic [SRC_W-1:0] msg_src, rep_dest_r,
  input logic [2:0] rep_class_r,
  input logic [3:0] rep_fields_r,
  input logic [55:0] msg_cmd, rep_cmd_r);
  wire t = clk_en & msg_valid & msg_ready;
  wire [4:0] f = {no_structure, unknown_cmd, syntax_bad, semantic_bad, order_bad};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_GBG: assert property (t && f[4] |=> rep_valid && rep_class_r == 3'h1) else $error("gbg");
  AST_BARE: assert property (rep_valid && rep_class_r == 3'h1 |-> !rep_echo_r &&
    rep_fields_r == 4'h2) else $error("bare");
  AST_UKN: assert property (t && f[4:3] == 2'h1 |=> rep_class_r == 3'h2) else $error("ukn");
  AST_ECHO: assert property (t && f != 0 && !f[4] |=> rep_echo_r &&
    rep_fields_r == 4'h4 && rep_cmd_r == $past(msg_cmd)) else $error("echo");
  AST_SYN: assert property (t && f[4:2] == 3'h1 |=> rep_class_r == 3'h3) else $error("syn");
  AST_SEM: assert property (t && f[4:1] == 4'h1 |=> rep_class_r == 3'h4) else $error("sem");
  AST_PRT: assert property (t && f == 5'h1 |=> rep_class_r == 3'h5) else $error("prt");
  AST_DEST: assert property (t && f != 0 |=> rep_dest_r == $past(msg_src)) else $error("dst");
  AST_CLEAN: assert property (t && f == 0 |=> msg_ok_r && !rep_valid) else $error("ok");
  cover property (t && f == 5'h1F);
  cover property (t && f == 0);
  cover property (rep_valid && !msg_ready);
endmodule // cmer_reporter_monitor
bind cmer_reporter cmer_reporter_monitor #(.SRC_W(SRC_W)) MON(.*);

//--- tb/cmer_reporter_test.sv
`timescale 1ns/1ps
module cmer_reporter_test;
  logic sys_clk = 0, rst_n = 0, msg_valid = 0, slow = 0, rep_ready, msg_ready, rep_valid;
  logic rep_echo_r, msg_ok_r;
  logic clk_en = 1;
  logic [3:0] msg_src = 0, rep_dest_r, rep_fields_r;
  logic [4:0] f = 0;
  logic [2:0] rep_class_r, e;
  logic [55:0] msg_cmd = 0, rep_cmd_r;
  logic [23:0] msg_ext = 0, rep_ext_r;
  logic [91:0] q[$];
  int mismatches = 0, total_checks = 0, i, k;
  wire [91:0] seen = msg_ok_r ? 92'h0 : {rep_class_r, rep_echo_r, rep_fields_r, rep_dest_r,
    rep_cmd_r, rep_ext_r};
  cmer_reporter DUT(.sys_clk, .rst_n, .clk_en, .msg_valid, .msg_ready, .msg_src,
    .msg_cmd, .msg_ext, .no_structure(f[4]), .unknown_cmd(f[3]), .syntax_bad(f[2]),
    .semantic_bad(f[1]), .order_bad(f[0]), .rep_valid, .rep_ready, .rep_dest_r, .rep_class_r,
    .rep_echo_r, .rep_fields_r, .rep_cmd_r, .rep_ext_r, .msg_ok_r);
  cmer_remote FAR(.sys_clk, .slow, .rep_ready);
  task check(input logic [91:0] s, x);
    total_checks++;
    if (s !== x) begin
      mismatches++;
      $display("Error reply exp %h seen %h", x, s);
    end
  endtask
  task complete_run;
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #12.5 sys_clk = ~sys_clk;
  // Random enable gaps; the design must freeze through them
  always @(posedge sys_clk) clk_en <= #1 !rst_n || $urandom_range(3) != 0;
  // Each accepted reply or clean pulse at an enabled edge retires the oldest note
  always @(posedge sys_clk) if (clk_en && (rep_valid && rep_ready || msg_ok_r)) begin
    if (q.size() == 0) mismatches++;
    else check(seen, q.pop_front());
  end
  // Single classes first, then random flag mixes to exercise priority
  initial begin
    i = $urandom(32'hD919);
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1;
    for (k = 0; k < 60; k++) begin
      {msg_src, msg_cmd, msg_ext} = 84'({$urandom, $urandom, $urandom});
      f = k < 6 ? 5'h10 >> k : 5'($urandom);
      slow = k[3];
      msg_valid = 1;
      e = f[4] ? 3'h1 : f[3] ? 3'h2 : f[2] ? 3'h3 : f[1] ? 3'h4 : f[0] ? 3'h5 : 3'h0;
      i = 0;
      do begin @(posedge sys_clk); i++; end while (!msg_ready && i < 200);
      if (!msg_ready) begin mismatches++; complete_run; end
      q.push_back(e == 0 ? 92'h0 : {e, e != 1, e == 1 ? 4'h2 : 4'h4, msg_src,
        e == 1 ? 80'h0 : {msg_cmd, msg_ext}});
      #1;
    end
    msg_valid = 0;
    repeat (200) @(posedge sys_clk);
    if (q.size() != 0) mismatches++;
    complete_run;
  end
endmodule // cmer_reporter_test
